/* File: hw/pin_ports_top.sv */
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pin_ports_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [11:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [11:0] araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic [31:0] pin_in,
  output logic [31:0]      pin_out,
  output logic [31:0]      pin_oe,
  input  wire logic [4:0]  strobe_in,
  output logic [4:0]       outbound_data_strobe,
  output logic [4:0]       port_event,
  output logic             pull_down_en
);
  typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} rd_state_e;

  localparam int NP = pin_port_pkg::NUM_PORTS;
  localparam int NC = pin_port_pkg::NUM_CLKBLK;

  logic [31:0] ctrl [NP];
  logic [15:0] sched [NP];
  logic [31:0] cond [NP];
  logic [8:0]  clk_cfg [NC];
  logic        link_en;
  logic [31:0] p_pins_out [NP];
  logic [31:0] p_xfer [NP];
  logic [15:0] p_count [NP];
  logic [15:0] p_stamp [NP];
  logic [NP-1:0] p_full;
  logic [NP-1:0] port_on;
  logic [NC-1:0] blk_tick;
  logic [31:0] pin_meta;
  logic [31:0] pin_sync;
  logic [4:0]  strobe_meta;
  logic [4:0]  strobe_sync;
  logic        aw_held;
  logic        w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;
  logic        wr_stall;
  logic [2:0]  wp;
  rd_state_e   rd_state;
  logic [11:0] rd_addr;
  logic [11:0] rd_src;
  logic [2:0]  rp;
  logic        rd_stall;
  logic        rd_load;
  logic [31:0] rd_mux;
  logic        rd_err;
  logic [31:0] next_pin_out;
  logic [31:0] next_pin_oe;
  logic [31:0] next_od_mask;
  logic [31:0] od_mask;

  port_lane_if lane [NP] ();

  // Address decode shared by both channels
  function automatic logic is_port(input logic [11:0] a);
    return a[11:8] == 4'h0 && int'(a[7:5]) < NP;
  endfunction

  function automatic logic is_clk(input logic [11:0] a);
    return a[11:5] == pin_port_pkg::CLKBLK_BASE[11:5]
           && int'(a[4:2]) < NC;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  function automatic logic [31:0] width_mask(input int p);
    return 32'((64'h1 << pin_port_pkg::PORT_WIDTH[p]) - 64'h1);
  endfunction

  // Two-stage synchronisers for pins and strobes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta <= 32'h0000_0000;
      pin_sync <= 32'h0000_0000;
      strobe_meta <= 5'h00;
      strobe_sync <= 5'h00;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      strobe_meta <= strobe_in;
      strobe_sync <= strobe_meta;
    end
  end

  // Pull-downs held on through reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pull_down_en <= 1'b1;
    else
      pull_down_en <= 1'b0;
  end

  // Clock blocks; block zero ticks every reference edge
  assign blk_tick[0] = 1'b1;
  generate
    for (genvar k = 1; k < NC; k++)
    begin : g_clk
      clock_block u_clk (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .src_pin   (clk_cfg[k][pin_port_pkg::CLK_SRC_PIN]),
        .pin_level (pin_sync[0]),
        .divide    (clk_cfg[k][7:0]),
        .tick      (blk_tick[k])
      );
    end
  endgenerate

  // Port instances and their lanes
  generate
    for (genvar p = 0; p < NP; p++)
    begin : g_port
      logic [2:0] sel;
      assign sel = ctrl[p][pin_port_pkg::CTRL_CLK_MSB:
                           pin_port_pkg::CTRL_CLK_LSB];
      assign port_on[p] = ctrl[p][pin_port_pkg::CTRL_EN]
                          && !(link_en && (width_mask(p)
                          & pin_port_pkg::LINK_PIN_MASK) != '0);
      assign lane[p].ctrl = {ctrl[p][31:1], port_on[p]};
      assign lane[p].sched = sched[p];
      assign lane[p].cond = cond[p];
      assign lane[p].wdata = w_data;
      assign lane[p].wr_data = do_write && !wr_stall && is_port(aw_addr)
                   && int'(wp) == p && aw_addr[4:0] == pin_port_pkg::REG_DATA
                   && ctrl[p][pin_port_pkg::CTRL_OUT];
      assign lane[p].rd_take = rd_load && is_port(rd_src) && int'(rp) == p
                   && rd_src[4:0] == pin_port_pkg::REG_DATA
                   && !ctrl[p][pin_port_pkg::CTRL_OUT];
      assign lane[p].tick = (int'(sel) < NC) ? blk_tick[sel] : 1'b0;
      assign lane[p].strobe_in = strobe_sync[p];
      assign lane[p].pins_in = pin_sync;
      assign p_pins_out[p] = lane[p].pins_out;
      assign p_xfer[p] = lane[p].xfer;
      assign p_count[p] = lane[p].count;
      assign p_stamp[p] = lane[p].stamp;
      assign p_full[p] = lane[p].full;
      assign outbound_data_strobe[p] = lane[p].strobe_out;
      assign port_event[p] = lane[p].event_pulse;
      timed_port #(.W(pin_port_pkg::PORT_WIDTH[p])) u_port (
        .aclk    (aclk),
        .aresetn (aresetn),
        .lane    (lane[p])
      );
    end
  endgenerate

  // Pin ownership: narrowest enabled port wins, link pins stay idle while the link is enabled
  always_comb
  begin
    logic drive;
    logic bit_v;
    logic od_v;
    drive = 1'b0;
    bit_v = 1'b0;
    od_v = 1'b0;
    next_pin_out = '0;
    next_pin_oe = '0;
    next_od_mask = '0;
    for (int i = 0; i < pin_port_pkg::PIN_W; i++)
    begin
      drive = 1'b0;
      bit_v = 1'b0;
      od_v = 1'b0;
      for (int p = NP - 1; p >= 0; p--)
      begin
        if (port_on[p] && i < pin_port_pkg::PORT_WIDTH[p])
        begin
          drive = ctrl[p][pin_port_pkg::CTRL_OUT];
          bit_v = p_pins_out[p][i];
          od_v = ctrl[p][pin_port_pkg::CTRL_OD];
        end
      end
      if (pin_port_pkg::LINK_PIN_MASK[i] && link_en)
        drive = 1'b0;
      next_od_mask[i] = od_v;
      next_pin_out[i] = od_v ? 1'b0 : bit_v;
      next_pin_oe[i] = drive && !(od_v && bit_v);
    end
  end

  // Registered pin drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_out <= 32'h0000_0000;
      pin_oe <= 32'h0000_0000;
      od_mask <= 32'h0000_0000;
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      od_mask <= next_od_mask;
    end
  end

  // Write channel capture, in either order
  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wp = aw_addr[7:5];
  assign wr_stall = is_port(aw_addr) && aw_addr[4:0] == pin_port_pkg::REG_DATA
                    && ctrl[wp][pin_port_pkg::CTRL_OUT] && p_full[wp];
  assign do_write = aw_held && w_held && !bvalid && !wr_stall;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= pin_port_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (is_port(aw_addr) || is_clk(aw_addr)
                  || aw_addr == pin_port_pkg::LINK_ADDR)
                 ? pin_port_pkg::RESP_OKAY : pin_port_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int p = 0; p < NP; p++)
      begin
        ctrl[p] <= pin_port_pkg::CTRL_RESET;
        sched[p] <= 16'h0000;
        cond[p] <= 32'h0000_0000;
      end
      for (int k = 0; k < NC; k++)
        clk_cfg[k] <= pin_port_pkg::CLK_CFG_RESET;
      link_en <= 1'b0;
    end
    else if (do_write)
    begin
      if (is_port(aw_addr))
      begin
        if (aw_addr[4:0] == pin_port_pkg::REG_CTRL)
          ctrl[wp] <= merge(ctrl[wp], w_data, w_strb);
        if (aw_addr[4:0] == pin_port_pkg::REG_TIME)
          sched[wp] <= 16'(merge({16'h0000, sched[wp]}, w_data, w_strb));
        if (aw_addr[4:0] == pin_port_pkg::REG_COND)
          cond[wp] <= merge(cond[wp], w_data, w_strb);
      end
      else if (is_clk(aw_addr) && aw_addr[4:2] != 3'h0)
        clk_cfg[aw_addr[4:2]] <= 9'(merge({23'h0, clk_cfg[aw_addr[4:2]]},
                                          w_data, w_strb));
      else if (aw_addr == pin_port_pkg::LINK_ADDR && w_strb[0])
        link_en <= w_data[0];
    end
  end

  // Read path; data reads of an enabled input port wait for a full transfer register
  assign arready = rd_state == RD_IDLE;
  assign rd_src = (rd_state == RD_IDLE) ? araddr : rd_addr;
  assign rp = rd_src[7:5];
  assign rd_stall = is_port(rd_src) && rd_src[4:0] == pin_port_pkg::REG_DATA
                    && port_on[rp] && !ctrl[rp][pin_port_pkg::CTRL_OUT]
                    && !p_full[rp];
  assign rd_load = ((rd_state == RD_IDLE && arvalid) || rd_state == RD_WAIT)
                   && !rd_stall;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (is_port(rd_src))
    begin
      case (rd_src[4:0])
        pin_port_pkg::REG_CTRL: rd_mux = ctrl[rp];
        pin_port_pkg::REG_DATA: rd_mux = p_xfer[rp];
        pin_port_pkg::REG_TIME: rd_mux = {16'h0000, sched[rp]};
        pin_port_pkg::REG_COUNT: rd_mux = {16'h0000, p_count[rp]};
        pin_port_pkg::REG_STAMP: rd_mux = {16'h0000, p_stamp[rp]};
        pin_port_pkg::REG_COND: rd_mux = cond[rp];
        pin_port_pkg::REG_STATUS: rd_mux = {31'h0, p_full[rp]};
        default: rd_err = 1'b1;
      endcase
    end
    else if (is_clk(rd_src))
      rd_mux = {23'h0, clk_cfg[rd_src[4:2]]};
    else if (rd_src == pin_port_pkg::LINK_ADDR)
      rd_mux = {31'h0, link_en};
    else
      rd_err = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_state <= RD_IDLE;
      rd_addr <= 12'h000;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= pin_port_pkg::RESP_OKAY;
    end
    else
    begin
      if (rd_state == RD_IDLE && arvalid)
        rd_addr <= araddr;
      if (rd_load)
      begin
        rd_state <= RD_RESP;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_err ? pin_port_pkg::RESP_SLVERR : pin_port_pkg::RESP_OKAY;
      end
      else if (rd_state == RD_IDLE && arvalid)
        rd_state <= RD_WAIT;
      else if (rd_state == RD_RESP && rready)
      begin
        rd_state <= RD_IDLE;
        rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_pulldown_reset: assert property ($rose(aresetn) |-> pull_down_en
    ##1 !pull_down_en) else $error("pull-down not held over reset");
  a_link_quiet: assert property (link_en |=> (pin_oe
    & pin_port_pkg::LINK_PIN_MASK) == '0)
    else $error("link pins still driven");
  a_narrow_owns: assert property (port_on[0] && !ctrl[0][1] |=> !pin_oe[0])
    else $error("wider port drove a taken pin");
  a_wide_keeps: assert property (port_on[4] && ctrl[4][1] && !ctrl[4][2]
    |=> pin_oe[20] && pin_out[20] == $past(p_pins_out[4][20]))
    else $error("wider port lost an unshared pin");
  a_open_drain: assert property ((pin_oe & pin_out & od_mask) == '0)
    else $error("open-drain pin driven high");
  a_read_stall: assert property (rd_state == RD_IDLE && arvalid && rd_stall
    |=> rd_state == RD_WAIT && !rvalid)
    else $error("input read answered without data");
  a_read_latency: assert property (arvalid && arready && !rd_stall |=> rvalid)
    else $error("read not answered next cycle");
  a_stamp_capture: assert property (lane[0].event_pulse
    |-> p_stamp[0] == $past(p_count[0]))
    else $error("timestamp does not match counter");
  a_count_wrap: assert property (lane[0].tick && p_count[0] == 16'hffff
    |=> p_count[0] == 16'h0000) else $error("counter did not wrap");
  a_count_step: assert property (lane[0].tick
    |=> p_count[0] == $past(p_count[0]) + 16'h0001)
    else $error("counter did not step");
  a_clk_zero: assert property ($rose(aresetn) |-> ctrl[0][10:8] == 3'h0
    && ctrl[4][10:8] == 3'h0)
    else $error("port not on block zero after reset");

  c_read_done: cover property (rvalid && rready);
  c_port_event: cover property (lane[0].event_pulse);
  c_read_waited: cover property (rd_state == RD_WAIT ##1 rvalid);
  c_link_write: cover property (link_en && bvalid);
endmodule
`default_nettype wire

/* File: hw/pin_port_pkg.sv */
package pin_port_pkg;
  localparam int NUM_PORTS = 5;
  localparam int NUM_CLKBLK = 6;
  localparam int PIN_W = 32;
  localparam int PORT_WIDTH [NUM_PORTS] = '{1, 4, 8, 16, 32};
  // Per-port register window
  localparam logic [11:0] PORT_STRIDE = 12'h020;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_DATA = 5'h04;
  localparam logic [4:0] REG_TIME = 5'h08;
  localparam logic [4:0] REG_COUNT = 5'h0c;
  localparam logic [4:0] REG_STAMP = 5'h10;
  localparam logic [4:0] REG_COND = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  localparam logic [11:0] CLKBLK_BASE = 12'h100;
  localparam logic [11:0] LINK_ADDR = 12'h120;
  // Control fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_OUT = 1;
  localparam int CTRL_OD = 2;
  localparam int CTRL_TIMED = 3;
  localparam int CTRL_COND = 4;
  localparam int CTRL_STROBE = 5;
  localparam int CTRL_CLK_LSB = 8;
  localparam int CTRL_CLK_MSB = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CLK_SRC_PIN = 8;
  localparam logic [8:0] CLK_CFG_RESET = 9'h000;
  localparam logic [31:0] LINK_PIN_MASK = 32'hff00_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: hw/port_lane_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface port_lane_if;
  logic [31:0] ctrl;
  logic [15:0] sched;
  logic [31:0] cond;
  logic [31:0] wdata;
  logic        wr_data;
  logic        rd_take;
  logic        tick;
  logic        strobe_in;
  logic [31:0] pins_in;
  logic [31:0] pins_out;
  logic [31:0] xfer;
  logic [15:0] count;
  logic [15:0] stamp;
  logic        full;
  logic        strobe_out;
  logic        event_pulse;
  modport ctl (output ctrl, sched, cond, wdata, wr_data, rd_take, tick,
               strobe_in, pins_in, input pins_out, xfer, count, stamp,
               full, strobe_out, event_pulse);
  modport port (input ctrl, sched, cond, wdata, wr_data, rd_take, tick,
                strobe_in, pins_in, output pins_out, xfer, count, stamp,
                full, strobe_out, event_pulse);
endinterface
`default_nettype wire

/* File: hw/clock_block.sv */
`timescale 1ns/1ns
`default_nettype none
module clock_block (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       src_pin,
  input  wire logic       pin_level,
  input  wire logic [7:0] divide,
  output logic            tick
);
  logic       pin_prev;
  logic [7:0] cnt;
  logic       src_event;

  // Source is every aclk edge or a rising edge of the one-bit port pin
  assign src_event = src_pin ? (pin_level && !pin_prev) : 1'b1;

  // Divide source events by divide plus one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_prev <= 1'b0;
      cnt <= 8'h00;
      tick <= 1'b0;
    end
    else
    begin
      pin_prev <= pin_level;
      tick <= 1'b0;
      if (src_event)
      begin
        if (cnt >= divide)
        begin
          cnt <= 8'h00;
          tick <= 1'b1;
        end
        else
          cnt <= cnt + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/timed_port.sv */
`timescale 1ns/1ns
`default_nettype none
module timed_port #(
  parameter int W = 1
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  port_lane_if.port  lane
);
  localparam int SLOTS = 32 / W;
  localparam logic [5:0] LAST = 6'(SLOTS - 1);
  logic [15:0] counter;
  logic [31:0] shift;
  logic [31:0] shifted_in;
  logic [5:0]  beat;
  logic        busy;
  logic        en;
  logic        out_mode;
  logic        time_ok;
  logic        cond_ok;
  logic        strobe_ok;
  logic        in_fire;
  logic        in_done;
  logic        out_load;
  logic        out_step;

  assign en = lane.ctrl[pin_port_pkg::CTRL_EN];
  assign out_mode = lane.ctrl[pin_port_pkg::CTRL_OUT];
  assign time_ok = !lane.ctrl[pin_port_pkg::CTRL_TIMED]
                   || counter == lane.sched;
  assign cond_ok = !lane.ctrl[pin_port_pkg::CTRL_COND]
                   || lane.pins_in[W-1:0] == lane.cond[W-1:0];
  assign strobe_ok = !lane.ctrl[pin_port_pkg::CTRL_STROBE]
                     || lane.strobe_in;
  // Gating of each sample and each word launch
  assign in_fire = en && !out_mode && lane.tick && strobe_ok
                   && (busy || (time_ok && cond_ok));
  assign in_done = in_fire && beat == LAST;
  assign out_load = en && out_mode && lane.tick && !busy && lane.full
                    && time_ok;
  assign out_step = en && out_mode && lane.tick && busy;

  // Deserialiser input, full word for the widest port
  generate
    if (W == 32)
    begin : g_whole
      assign shifted_in = lane.pins_in;
    end
    else
    begin : g_part
      assign shifted_in = {lane.pins_in[W-1:0], shift[31:W]};
    end
  endgenerate

  // Free-running port counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      counter <= 16'h0000;
    else if (lane.tick)
      counter <= counter + 16'h0001;
  end

  // Shift register, pin drive and timestamp
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      shift <= 32'h0000_0000;
      beat <= 6'h00;
      busy <= 1'b0;
      lane.pins_out <= 32'h0000_0000;
      lane.stamp <= 16'h0000;
    end
    else if (!en)
    begin
      busy <= 1'b0;
      beat <= 6'h00;
    end
    else if (in_fire)
    begin
      shift <= shifted_in;
      if (beat == LAST)
      begin
        busy <= 1'b0;
        beat <= 6'h00;
        lane.stamp <= counter;
      end
      else
      begin
        busy <= 1'b1;
        beat <= beat + 6'h01;
      end
    end
    else if (out_load)
    begin
      lane.pins_out <= lane.xfer;
      shift <= lane.xfer >> W;
      lane.stamp <= counter;
      busy <= (SLOTS > 1);
      beat <= 6'h00;
    end
    else if (out_step)
    begin
      lane.pins_out <= shift;
      shift <= shift >> W;
      beat <= beat + 6'h01;
      if (beat + 6'h01 == LAST)
        busy <= 1'b0;
    end
  end

  // Transfer register; a fill wins over a same-cycle take
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lane.xfer <= 32'h0000_0000;
      lane.full <= 1'b0;
    end
    else if (in_done)
    begin
      lane.xfer <= shifted_in;
      lane.full <= 1'b1;
    end
    else if (lane.wr_data)
    begin
      lane.xfer <= lane.wdata;
      lane.full <= 1'b1;
    end
    else if (lane.rd_take || out_load)
      lane.full <= 1'b0;
  end

  // Strobe beside output data and scheduler event
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lane.strobe_out <= 1'b0;
      lane.event_pulse <= 1'b0;
    end
    else
    begin
      lane.strobe_out <= lane.ctrl[pin_port_pkg::CTRL_STROBE]
                         && (out_load || out_step);
      lane.event_pulse <= in_done || out_load;
    end
  end

  assign lane.count = counter;
endmodule
`default_nettype wire

/* File: bench/pin_partner.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic        pull_down_en,
  input  wire logic [7:0]  pattern,
  output logic [31:0]      pin_in,
  output logic [4:0]       strobe_in
);
  // Driven pins read back; others pulled down in reset, else pattern
  always_comb
  begin
    for (int i = 0; i < 32; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i]
                : (pull_down_en ? 1'b0 : pattern[i % 8]);
  end
  // Strobes held off
  assign strobe_in = 5'h00;
endmodule
`default_nettype wire

/* File: bench/timed_pin_ports_with_clock_blocks_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module timed_pin_ports_with_clock_blocks_bench;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pull_down_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, pin_in, pin_out, pin_oe;
  logic [1:0]  bresp, rresp;
  logic [4:0]  strobe_in, outbound_data_strobe, port_event;
  logic [7:0]  pat;
  logic [33:0] expect_q[$];
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          events = 0;
  int          strobes = 0;
  pin_ports_top pin_ports_top_inst (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid,
    .rready, .rdata, .rresp, .pin_in, .pin_out, .pin_oe, .strobe_in,
    .outbound_data_strobe, .port_event, .pull_down_en);
  pin_partner pin_partner_inst (.pin_out, .pin_oe, .pull_down_en,
    .pattern(pat), .pin_in, .strobe_in);
  // Clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Write: address and data together, then wait for response
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (awvalid || wvalid)
    begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do
    begin
      @(negedge aclk);
      ta = bvalid;
      @(posedge aclk);
    end
    while (!ta);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Read: note the expected answer, then run the handshake
  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    logic t;
    expect_q.push_back(exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
    end
    while (!t);
    arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      t = rvalid;
      @(posedge aclk);
    end
    while (!t);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Compare each read answer with the oldest note
  always @(posedge aclk)
    if (aresetn && rvalid && rready)
      check({rresp, rdata}, expect_q.pop_front());
  // Count launches and strobes of the widest port
  always @(posedge aclk)
    if (aresetn)
    begin
      events += port_event[4];
      strobes += outbound_data_strobe[4];
    end
  // Hang guard
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test;
    end
  end
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 56'h0;
    void'($urandom(549));
    pat = 8'($urandom);
    repeat (16) @(posedge aclk);
    check({pull_down_en, pin_oe == 32'h0}, 34'h3);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Control of every port reads zero after reset
    for (int p = 0; p < 5; p++)
      rd(12'(p) * pin_port_pkg::PORT_STRIDE, 34'h0);
    rd(12'h200, {pin_port_pkg::RESP_SLVERR, 32'h0});
    wr(12'h48, 32'h0000_1234);
    rd(12'h48, 34'h1234);
    // 8-bit input port assembles four slices, read stalls for the word
    wr(12'h40, 32'h1);
    rd(12'h44, {2'h0, {4{pat}}});
    wr(12'h40, 32'h0);
    // Open-drain 1-bit port: zero pulls low, one releases
    wr(12'h00, 32'h7);
    wr(12'h04, 32'h0);
    repeat (4) @(posedge aclk);
    check({pin_oe[0], pin_out[0]}, 34'h2);
    wr(12'h04, 32'hffff_ffff);
    repeat (40) @(posedge aclk);
    check(pin_oe[0], 34'h0);
    // Wide port keeps unshared pins until the link claims them
    wr(12'h80, 32'h23);
    wr(12'h84, 32'hffff_ffff);
    repeat (5) @(posedge aclk);
    check(pin_oe[31:24], 34'hff);
    check({strobes[15:0], events[15:0]}, 34'h1_0001);
    wr(pin_port_pkg::LINK_ADDR, 32'h1);
    repeat (5) @(posedge aclk);
    check(pin_oe[31:24], 34'h0);
    // Narrow input port takes pin 0, wide port keeps pin 1
    wr(pin_port_pkg::LINK_ADDR, 32'h0);
    wr(12'h00, 32'h1);
    repeat (5) @(posedge aclk);
    check(pin_oe[1:0], 34'h2);
    finish_test;
  end
endmodule
`default_nettype wire
